//--- core/fault_detector_defines.vh
// Constants for the supply fault detector bank
`ifndef FAULT_DETECTOR_DEFINES_VH
`define FAULT_DETECTOR_DEFINES_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_FAULT 8'h0c
`define REG_LOGIC 8'h10
`define REG_CH_BASE 8'h40
`define REG_CH_STRIDE 8'h10
// Per-channel word index within the channel block
`define CHW_CFG 2'd0
`define CHW_UV 2'd1
`define CHW_OV 2'd2
`define CHW_GLITCH 2'd3
// Channel config field positions
`define CFG_MODE_LSB 0
`define CFG_RANGE_LSB 2
`define CFG_HYST_LSB 8
// Fault modes
`define MODE_UV 2'd0
`define MODE_OV 2'd1
`define MODE_WIN 2'd2
`define MODE_OFF 2'd3
// Range codes; bottom and span in millivolts
`define RANGE_LOW 2'd0
`define RANGE_MID 2'd1
`define RANGE_HIGH 2'd2
`define RANGE_TOP 2'd3
`define RB0_MV 16'd573
`define RS0_MV 16'd802
`define RB1_MV 16'd1250
`define RS1_MV 16'd1750
`define RB2_MV 16'd2500
`define RS2_MV 16'd3500
`define RB3_MV 16'd4800
`define RS3_MV 16'd9600
`define CODE_FULL 16'd255
`define HYST_MAX 5'd31
// Glitch filter timing
`define CLK_MHZ 100
`define GLITCH_MAX_US 100
`define GLITCH_MAX_CYC (`GLITCH_MAX_US * `CLK_MHZ)
`define GLITCH_CYC_PER_US `CLK_MHZ
// Reset values
`define CTRL_RST 5'h00
`define CFG_RST 16'h0000
`define UV_RST 8'h00
`define OV_RST 8'hff
`define GLITCH_RST 7'h00
`endif

//--- core/glitch_filter.v
// Glitch filter: output follows input once it has held for the timeout
`timescale 1ns/1ps
module glitch_filter (
  input wire clk_i, // System clock
  input wire rst_i, // Synchronous reset
  input wire raw_i, // Unfiltered fault level
  input wire [13:0] limit_i, // Timeout in clock cycles
  output reg filt_o // Filtered fault level
);
  reg [13:0] cnt_q;

  // Count while input differs from output; commit when timeout reached
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 14'h0000;
      filt_o <= 1'b0;
    end else if (raw_i == filt_o) begin
      cnt_q <= 14'h0000; // Short pulse dropped
    end else if (cnt_q + 14'h0001 >= limit_i) begin
      cnt_q <= 14'h0000;
      filt_o <= raw_i; // Passed edge delayed by timeout
    end else begin
      cnt_q <= cnt_q + 14'h0001;
    end
  end
endmodule

//--- core/supply_fault_detector.v
// Digital logic of a ten-channel supply fault detector bank
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "fault_detector_defines.vh"
module supply_fault_detector (
  input wire clk_i, // System clock, 100 MHz
  input wire rst_i, // Synchronous reset, active high
  input wire [31:0] adr_i, // Wishbone byte address
  input wire [31:0] dat_i, // Wishbone write data
  input wire [3:0] sel_i, // Wishbone byte enables
  input wire we_i, // Wishbone write enable
  input wire cyc_i, // Wishbone cycle
  input wire stb_i, // Wishbone strobe
  output reg [31:0] dat_o, // Wishbone read data
  output reg ack_o, // Wishbone acknowledge
  input wire [15:0] level_mv_i [0:9], // Sensed level per channel, millivolts
  input wire [4:0] dual_function_input_i, // Dual-function pins as logic levels
  output reg [9:0] fault_o, // Filtered fault per channel
  output reg [4:0] logic_o, // Filtered logic inputs
  output reg irq_o // Interrupt, level
);
  // Per-channel configuration storage
  reg [4:0] dual_logic_q; // 1: dual channel is a logic input
  reg [1:0] mode_q [0:9];
  reg [1:0] range_q [0:9];
  reg [4:0] hyst_q [0:9];
  reg [7:0] uv_q [0:9];
  reg [7:0] ov_q [0:9];
  reg [6:0] glitch_q [0:9]; // Timeout in microseconds
  reg [9:0] state_q; // Comparator state with hysteresis
  reg [9:0] status_q;
  reg [9:0] mask_q;
  reg [9:0] fault_prev_q;
  reg [4:0] sync1_q, sync2_q, sync3_q, logic_q;
  wire [9:0] filt;
  wire [9:0] fault_edge;
  wire [9:0] now_all; // Next comparator state per channel
  wire [7:0] ch_off; // Offset inside the channel block area
  wire [7:0] off;
  wire [3:0] ch_sel;
  wire [1:0] ch_word;
  wire in_ch;
  wire acc;
  wire wr;

  assign acc = cyc_i & stb_i & ~ack_o;
  // A write lands on the edge at which the master sees acknowledge
  assign wr = cyc_i & stb_i & ack_o & we_i & sel_i[0];
  assign off = adr_i[7:0];
  assign in_ch = (off >= `REG_CH_BASE) && (off < `REG_CH_BASE + 8'd160);
  assign ch_off = off - `REG_CH_BASE;
  assign ch_sel = in_ch ? ch_off[7:4] : 4'h0;
  assign ch_word = off[3:2];
  assign fault_edge = fault_o & ~fault_prev_q;

  // Range bottom in millivolts, dual channels in detector mode forced to the lowest range
  function [15:0] bottom_mv;
    input [1:0] r;
    begin
      case (r)
        `RANGE_LOW: bottom_mv = `RB0_MV;
        `RANGE_MID: bottom_mv = `RB1_MV;
        `RANGE_HIGH: bottom_mv = `RB2_MV;
        default: bottom_mv = `RB3_MV;
      endcase
    end
  endfunction

  function [15:0] span_mv;
    input [1:0] r;
    begin
      case (r)
        `RANGE_LOW: span_mv = `RS0_MV;
        `RANGE_MID: span_mv = `RS1_MV;
        `RANGE_HIGH: span_mv = `RS2_MV;
        default: span_mv = `RS3_MV;
      endcase
    end
  endfunction

  // Threshold or hysteresis in millivolts: span times code over 255
  function [15:0] code_mv;
    input [1:0] r;
    input [7:0] code;
    reg [23:0] prod;
    reg [23:0] quo;
    begin
      prod = span_mv(r) * code;
      quo = prod / `CODE_FULL;
      code_mv = quo[15:0];
    end
  endfunction

  // Range in effect for channel i; dual channels in detector mode use lowest
  function [1:0] eff_range;
    input integer i;
    begin
      if (i < 5)
        eff_range = range_q[i];
      else if (!dual_logic_q[i-5])
        eff_range = `RANGE_LOW;
      else
        eff_range = range_q[i-5]; // Warning detector tracks partner range
    end
  endfunction

  // Level seen by channel i; logic-mode dual channels watch their partner
  function [15:0] sense_mv;
    input integer i;
    begin
      if (i >= 5 && dual_logic_q[i-5])
        sense_mv = level_mv_i[i-5]; // Channel 9 pairs with the high-voltage input
      else
        sense_mv = level_mv_i[i];
    end
  endfunction

  // Comparators with hysteresis, one per channel
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : ch
      wire [1:0] rg;
      wire [15:0] lvl, uv_t, ov_t, hy;
      wire [13:0] lim;
      wire uv_set, ov_set, uv_hold, ov_hold, now;
      assign rg = eff_range(g);
      assign lvl = sense_mv(g);
      assign uv_t = bottom_mv(rg) + code_mv(rg, uv_q[g]);
      assign ov_t = bottom_mv(rg) + code_mv(rg, ov_q[g]);
      assign hy = code_mv(rg, {3'b000, hyst_q[g]});
      assign lim = {7'h00, glitch_q[g]} * 14'd`GLITCH_CYC_PER_US;
      assign uv_set = lvl < uv_t;
      assign ov_set = lvl > ov_t;
      // Active fault clears only past the hysteresis band
      assign uv_hold = lvl <= uv_t + hy;
      assign ov_hold = (ov_t < hy) ? 1'b1 : (lvl >= ov_t - hy);
      assign now = state_q[g] ? ((mode_q[g] == `MODE_UV) ? uv_hold :
                                 (mode_q[g] == `MODE_OV) ? ov_hold :
                                 (mode_q[g] == `MODE_WIN) ? (uv_hold | ov_hold) : 1'b0)
                              : ((mode_q[g] == `MODE_UV) ? uv_set :
                                 (mode_q[g] == `MODE_OV) ? ov_set :
                                 (mode_q[g] == `MODE_WIN) ? (uv_set | ov_set) : 1'b0);
      assign now_all[g] = now;
      // Glitch filter as final stage
      glitch_filter u_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(state_q[g]),
        .limit_i(lim),
        .filt_o(filt[g])
      );
    end
  endgenerate

  // Comparator state register, one driver for all channels
  always @(posedge clk_i) begin
    if (rst_i)
      state_q <= 10'h000;
    else
      state_q <= now_all;
  end

  // Register writes and configuration
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      dual_logic_q <= `CTRL_RST;
      mask_q <= 10'h000;
      for (i = 0; i < 10; i = i + 1) begin
        mode_q[i] <= `MODE_UV;
        range_q[i] <= `RANGE_LOW;
        hyst_q[i] <= 5'h00;
        uv_q[i] <= `UV_RST;
        ov_q[i] <= `OV_RST;
        glitch_q[i] <= `GLITCH_RST;
      end
    end else if (wr) begin
      if (off == `REG_CTRL)
        dual_logic_q <= dat_i[4:0]; // One role per dual channel
      else if (off == `REG_MASK)
        mask_q <= dat_i[9:0];
      else if (in_ch) begin
        case (ch_word)
          `CHW_CFG: begin
            mode_q[ch_sel] <= dat_i[`CFG_MODE_LSB +: 2];
            range_q[ch_sel] <= dat_i[`CFG_RANGE_LSB +: 2];
            hyst_q[ch_sel] <= dat_i[`CFG_HYST_LSB +: 5];
          end
          `CHW_UV: uv_q[ch_sel] <= dat_i[7:0];
          `CHW_OV: ov_q[ch_sel] <= dat_i[7:0];
          default: glitch_q[ch_sel] <= (dat_i[6:0] > 7'd`GLITCH_MAX_US) ?
                                       7'd`GLITCH_MAX_US : dat_i[6:0];
        endcase
      end
    end
  end

  // Sticky status, set wins over write-one-to-clear; interrupt from masked status
  always @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= 10'h000;
      irq_o <= 1'b0;
    end else begin
      status_q <= (status_q & ~((wr && off == `REG_STATUS) ? dat_i[9:0] : 10'h000))
                  | fault_edge;
      irq_o <= |(status_q & mask_q);
    end
  end

  // Fault outputs and logic input synchroniser
  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 10'h000;
      fault_prev_q <= 10'h000;
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
      logic_q <= 5'h00;
      logic_o <= 5'h00;
    end else begin
      fault_o <= filt; // One registered bit per channel
      fault_prev_q <= fault_o;
      sync1_q <= dual_function_input_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      logic_q <= (sync2_q & ~(sync2_q ^ sync3_q)) | (logic_q & (sync2_q ^ sync3_q));
      logic_o <= logic_q & dual_logic_q; // Logic input only in logic role
    end
  end

  // Wishbone read and acknowledge, registered, one wait cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= acc;
      dat_o <= 32'h00000000;
      if (acc && !we_i) begin
        if (off == `REG_CTRL)
          dat_o <= {27'h0, dual_logic_q};
        else if (off == `REG_STATUS)
          dat_o <= {22'h0, status_q};
        else if (off == `REG_MASK)
          dat_o <= {22'h0, mask_q};
        else if (off == `REG_FAULT)
          dat_o <= {22'h0, fault_o};
        else if (off == `REG_LOGIC)
          dat_o <= {27'h0, logic_o};
        else if (in_ch) begin
          case (ch_word)
            `CHW_CFG: dat_o <= {19'h0, hyst_q[ch_sel], 4'h0, range_q[ch_sel], mode_q[ch_sel]};
            `CHW_UV: dat_o <= {24'h0, uv_q[ch_sel]};
            `CHW_OV: dat_o <= {24'h0, ov_q[ch_sel]};
            default: dat_o <= {25'h0, glitch_q[ch_sel]};
          endcase
        end
      end
    end
  end
endmodule

//--- sim/rail_model.sv
// Behavioural model of the monitored rails and dual-function pins
`timescale 1ns/1ps
module rail_model (
  input wire clk_i, // Clock for update timing
  output logic [15:0] level_mv_o [0:9], // Rail levels in millivolts
  output logic [4:0] pins_o // Dual-function pins as logic levels
);
  // All ten rails start well above the default thresholds
  initial begin
    for (int k = 0; k < 10; k++) begin
      level_mv_o[k] = 16'd3000;
    end
    pins_o = 5'h00;
  end
  // Move one rail just after the next edge
  task automatic set_rail(input int ch, input logic [15:0] mv);
    @(posedge clk_i);
    level_mv_o[ch] <= mv;
  endtask
  // Change the logic pins just after the next edge
  task automatic set_pins(input logic [4:0] v);
    @(posedge clk_i);
    pins_o <= v;
  endtask
endmodule

//--- sim/supply_fault_detector_sva.sv
// Port-level checks for the supply fault detector bank
`timescale 1ns/1ps
module supply_fault_detector_sva (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire [31:0] adr_i, // Address
  input wire [31:0] dat_i, // Write data
  input wire [3:0] sel_i, // Byte enables
  input wire we_i, // Write enable
  input wire cyc_i, // Cycle
  input wire stb_i, // Strobe
  input wire [31:0] dat_o, // Read data
  input wire ack_o, // Acknowledge
  input wire [15:0] level_mv_i [0:9], // Sensed levels
  input wire [4:0] dual_function_input_i, // Logic pins
  input wire [9:0] fault_o, // Faults
  input wire [4:0] logic_o, // Logic levels
  input wire irq_o // Interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  logic [9:0] mask_q;
  logic [4:0] role_q;
  logic [3:0] age_q;
  logic [13:0] cnt_q;
  logic [13:0] lim_q;
  logic [15:0] lvl_q;
  wire wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  // Shadow of mask, role and channel 0 timeout; counter of settled cycles
  always @(posedge clk_i) begin
    lvl_q <= level_mv_i[0];
    if (rst_i || wr || level_mv_i[0] != lvl_q) cnt_q <= 14'h0000;
    else if (cnt_q != 14'h3000) cnt_q <= cnt_q + 14'h0001;
    if (rst_i || (wr && adr_i[7:0] == 8'h00)) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
    if (rst_i) begin
      mask_q <= 10'h000;
      role_q <= 5'h00;
      lim_q <= 14'h0001;
    end else if (wr) begin
      if (adr_i[7:0] == 8'h08) mask_q <= dat_i[9:0];
      if (adr_i[7:0] == 8'h00) role_q <= dat_i[4:0];
      if (adr_i[7:0] == 8'h4c) lim_q <= (dat_i[6:0] == 7'h00) ? 14'h0001 :
        (dat_i[6:0] > 7'h64 ? 14'h2710 : dat_i[6:0] * 14'h0064);
    end
  end
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  ack_follow_a: assert property (disable iff (rst_i) bus_req |=> ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (disable iff (rst_i) ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (disable iff (rst_i) ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  reset_quiet_a: assert property (rst_i |=> fault_o == 10'h000 && !irq_o && !ack_o)
    else $error("outputs not cleared by reset");
  logic_role_a: assert property (disable iff (rst_i) age_q == 4'hf |-> (logic_o & ~role_q) == 5'h00)
    else $error("logic level from analog channel");
  irq_raise_a: assert property (disable iff (rst_i)
    (fault_o & ~$past(fault_o) & mask_q) != 10'h000 |-> ##[1:3] irq_o)
    else $error("unmasked fault raised no interrupt");
  irq_mask_a: assert property (disable iff (rst_i)
    mask_q == 10'h000 && $past(mask_q) == 10'h000 |-> !irq_o)
    else $error("interrupt while fully masked");
  glitch_hold_a: assert property (disable iff (rst_i) $changed(fault_o[0]) |-> cnt_q + 14'h0002 >= lim_q)
    else $error("fault moved before the filter timeout");
endmodule
bind supply_fault_detector supply_fault_detector_sva supply_fault_detector_sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .level_mv_i(level_mv_i),
  .dual_function_input_i(dual_function_input_i), .fault_o(fault_o), .logic_o(logic_o),
  .irq_o(irq_o));

//--- sim/tb_top.sv
// Self-checking bench for the supply fault detector bank
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, q;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  wire [31:0] dat_o;
  wire ack_o, irq_o;
  wire [9:0] fault_o;
  wire [4:0] logic_o, pins;
  wire [15:0] lv [0:9];
  int error_cnt = 0, checks_done = 0, n;
  logic [1:0] modes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic exps [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  always #5 clk_i = ~clk_i;
  rail_model rail_model_i (.clk_i(clk_i), .level_mv_o(lv), .pins_o(pins));
  supply_fault_detector supply_fault_detector_i (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(4'hf), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .level_mv_i(lv), .dual_function_input_i(pins),
    .fault_o(fault_o), .logic_o(logic_o), .irq_o(irq_o));
  // Verdict and end of run
  task final_report;
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Compare and report
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic bus cycle; read data lands in q
  task wb(input [7:0] a, input w, input [31:0] d);
    int k;
    adr_i <= {24'h0, a};
    we_i <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    k = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      k++;
      if (k > 20) begin
        error_cnt++;
        final_report;
      end
      @(posedge clk_i);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Bounded wait for channel 0 to reach a level; n counts edges
  task wait_f(input logic v);
    n = 0;
    while (fault_o[0] !== v && n < 400) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(fault_o, 32'h0);
    wb(8'h44, 0, 0); chk(q, 32'h0);
    wb(8'h48, 0, 0); chk(q, 32'hff);
    wb(8'h3c, 0, 0); chk(q, 32'h0);
    wb(8'h08, 1, 32'h3ff);
    wb(8'h40, 1, 32'h0a00);
    wb(8'h44, 1, 32'h80);
    wb(8'h4c, 1, 32'h1);
    wb(8'h40, 0, 0); chk(q, 32'h0a00);
    // Threshold 975 mV, hysteresis 31 mV, timeout 100 cycles
    rail_model_i.set_rail(0, 16'd1000);
    repeat (150) @(posedge clk_i);
    rail_model_i.set_rail(0, 16'd900);
    repeat (50) @(posedge clk_i);
    rail_model_i.set_rail(0, 16'd1010);
    repeat (150) @(posedge clk_i);
    chk(fault_o[0], 0);
    rail_model_i.set_rail(0, 16'd900);
    wait_f(1'b1);
    chk(n >= 100 && n <= 106, 1);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1);
    wb(8'h04, 0, 0); chk(q[0], 1);
    // Inside the hysteresis band the fault holds
    rail_model_i.set_rail(0, 16'd1000);
    repeat (200) @(posedge clk_i);
    chk(fault_o[0], 1);
    rail_model_i.set_rail(0, 16'd1010);
    wait_f(1'b0);
    chk(fault_o[0], 0);
    chk(irq_o, 1);
    wb(8'h04, 1, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0);
    // Each mode at 1010 mV with an over threshold of 774 mV
    wb(8'h48, 1, 32'h40);
    for (int m = 0; m < 4; m++) begin
      wb(8'h40, 1, {30'h0, modes[m]});
      repeat (200) @(posedge clk_i);
      chk(fault_o[0], exps[m]);
    end
    // Channel 5 asks for the high range at 3000 mV but is held to the lowest
    wb(8'h90, 1, 32'h9);
    repeat (10) @(posedge clk_i);
    chk(fault_o[5], 1);
    // Dual channel in logic role passes its pin, in analog role it does not
    wb(8'h00, 1, 32'h1);
    rail_model_i.set_pins(5'h01);
    repeat (20) @(posedge clk_i);
    chk(logic_o, 32'h1);
    chk(fault_o[5], 0);
    wb(8'h00, 1, 32'h0);
    repeat (20) @(posedge clk_i);
    chk(logic_o, 32'h0);
    wb(8'h08, 1, 32'h0);
    final_report;
  end
endmodule
